//--- rtl/adc_start_status_control.sv
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
module adc_start_status_control (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] pwdata,
    output logic [adc_ctrl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // external start pin, asynchronous
    input wire logic ext_start_pin,
    // converter core and multiplexer
    input wire logic [adc_ctrl_pkg::RES_W-1:0] coreResult,
    output logic convStart,
    output logic [adc_ctrl_pkg::CHAN_W-1:0] chanSel,
    output logic irq
);
    import adc_ctrl_pkg::*;

    // register state
    logic ext_start_enable;
    logic conversion_done_flag;
    logic [CHAN_W-1:0] channelSelect;
    logic [RES_W-1:0] resultReg;
    logic [INT_W-1:0] intStatus;
    logic [INT_W-1:0] intMask;

    // conversion state
    conv_state_t state;
    logic startCmd;
    logic start_busy_bit;
    logic [PRE_W-1:0] prescale;
    logic mcTick;
    logic [MC_W-1:0] mcCount;

    // external start detection
    logic extSync;
    logic extLevelNow;
    logic extLevelPrev;
    logic extRise;

    // bus decode
    logic access;
    logic wrStrobe;
    logic rdSetup;
    logic swStart;
    logic startReq;
    logic startOk;
    logic startRejected;
    logic finishNow;
    logic ctrlWrite;
    logic rdCapture;
    logic extStart;
    logic [INT_W-1:0] intEvent;
    logic [INT_W-1:0] intClear;
    logic next_irq;
    logic [DATA_W-1:0] next_prdata;

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = (a == CTRL_OFS) || (a == RESULT_OFS) ||
                   (a == INT_STATUS_OFS) || (a == INT_MASK_OFS);
    endfunction

    function automatic logic hits(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] ofs);
        hits = (a == ofs);
    endfunction

    function automatic logic [BYTE_W-1:0] ctrlByte(
        input logic [1:0] resLo, input logic extEn, input logic done,
        input logic busy, input logic [CHAN_W-1:0] chan);
        ctrlByte = {resLo, extEn, done, busy, chan};
    endfunction

    pin_sync u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .pinIn(ext_start_pin),
        .pinOut(extSync)
    );

    // apb handshake: access phase answered one cycle after it begins
    assign access = psel & penable;
    assign rdSetup = access & ~pready;
    assign wrStrobe = access & pready & pwrite & isMapped(paddr);
    assign ctrlWrite = wrStrobe & hits(paddr, CTRL_OFS);
    assign rdCapture = rdSetup & ~pwrite;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
        end else if (ce) begin
            pready <= rdSetup;
        end
    end

    // error answer rides on the same cycle as ready
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pslverr <= 1'b0;
        end else if (ce) begin
            pslverr <= rdSetup & ~isMapped(paddr);
        end
    end

    always_comb begin
        next_prdata = '0;
        if (hits(paddr, CTRL_OFS)) begin
            next_prdata[BYTE_W-1:0] = ctrlByte(resultReg[1:0],
                ext_start_enable, conversion_done_flag, start_busy_bit,
                channelSelect);
        end else if (hits(paddr, RESULT_OFS)) begin
            next_prdata[BYTE_W-1:0] = resultReg[RES_W-1:2];
        end else if (hits(paddr, INT_STATUS_OFS)) begin
            next_prdata[INT_W-1:0] = intStatus;
        end else if (hits(paddr, INT_MASK_OFS)) begin
            next_prdata[INT_W-1:0] = intMask;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (ce) begin
            if (rdCapture) begin
                prdata <= next_prdata;
            end
        end
    end

    // machine-cycle timebase; restarts with each conversion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= '0;
        end else if (ce) begin
            if (startOk || prescale == PRE_LAST) begin
                prescale <= '0;
            end else begin
                prescale <= prescale + 1'b1;
            end
        end
    end
    assign mcTick = (prescale == PRE_LAST);

    // pin level sampled once per machine cycle end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // idle-high reset level, so leaving reset is never a rising edge
            extLevelNow <= 1'b1;
            extLevelPrev <= 1'b1;
        end else if (ce) begin
            if (mcTick) begin
                extLevelNow <= extSync;
                extLevelPrev <= extLevelNow;
            end
        end
    end
    assign extRise = extLevelNow & ~extLevelPrev;

    // start arbitration
    assign swStart = ctrlWrite & pwdata[BUSY_BIT];
    assign extStart = ext_start_enable & extRise & mcTick;
    assign startReq = swStart | extStart;
    assign startOk = startReq & ~start_busy_bit
                   & ~conversion_done_flag;
    assign startRejected = startReq & ~startOk;
    assign finishNow = startCmd & mcTick
                     & (mcCount == CONV_LAST - 1'b1);

    // conversion sequencer: idle, counting machine cycles, closing cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    if (startOk) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (finishNow) begin
                        state <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // command flop: set by an accepted start, dropped at completion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            startCmd <= 1'b0;
        end else if (ce) begin
            if (startOk) begin
                startCmd <= 1'b1;
            end else if (finishNow) begin
                startCmd <= 1'b0;
            end
        end
    end

    // status flag seen by software; clears one clock after the done flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_busy_bit <= 1'b0;
        end else if (ce) begin
            if (startOk) begin
                start_busy_bit <= 1'b1;
            end else if (state == ST_FINISH) begin
                start_busy_bit <= 1'b0;
            end
        end
    end

    // machine cycles elapsed since the command flop was set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mcCount <= '0;
        end else if (ce) begin
            if (startOk) begin
                mcCount <= '0;
            end else if (startCmd && mcTick) begin
                mcCount <= mcCount + 1'b1;
            end
        end
    end

    // launch strobe to the converter core, one clock wide
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            convStart <= 1'b0;
        end else if (ce) begin
            convStart <= startOk;
        end
    end

    // result capture at completion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resultReg <= '0;
        end else if (ce) begin
            if (finishNow) begin
                resultReg <= coreResult;
            end
        end
    end

    // done flag: hardware set wins over a software clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conversion_done_flag <= CTRL_RESET[DONE_BIT];
        end else if (ce) begin
            if (finishNow) begin
                conversion_done_flag <= 1'b1;
            end else if (ctrlWrite && !pwdata[DONE_BIT]) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // start mode select, software owned
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_start_enable <= CTRL_RESET[EXT_EN_BIT];
        end else if (ce) begin
            if (ctrlWrite) begin
                ext_start_enable <= pwdata[EXT_EN_BIT];
            end
        end
    end

    // channel field; a change while busy is not blocked here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channelSelect <= CTRL_RESET[CHAN_HI:CHAN_LO];
        end else if (ce) begin
            if (ctrlWrite) begin
                channelSelect <= pwdata[CHAN_HI:CHAN_LO];
            end
        end
    end

    // channel n drives mux input n
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chanSel <= '0;
        end else if (ce) begin
            chanSel <= channelSelect;
        end
    end

    // interrupt events and write-one-to-clear strobes, one bit each
    assign intEvent[IRQ_DONE_BIT] = finishNow;
    assign intEvent[IRQ_REJECT_BIT] = startRejected;
    assign intClear = (wrStrobe && hits(paddr, INT_STATUS_OFS))
                    ? pwdata[INT_W-1:0] : '0;

    // sticky status bits; a set wins over a clear in the same cycle
    for (genvar g = 0; g < INT_W; g++) begin : g_int_status
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                intStatus[g] <= INT_RESET[g];
            end else if (ce) begin
                if (intEvent[g]) begin
                    intStatus[g] <= 1'b1;
                end else if (intClear[g]) begin
                    intStatus[g] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intMask <= INT_RESET;
        end else if (ce) begin
            if (wrStrobe && hits(paddr, INT_MASK_OFS)) begin
                intMask <= pwdata[INT_W-1:0];
            end
        end
    end

    // the done flag keeps the request up while it stays set and its mask bit is on
    assign next_irq = (|(intStatus & intMask))
                    | (conversion_done_flag & intMask[IRQ_DONE_BIT]);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= next_irq;
        end
    end
endmodule // adc_start_status_control

//--- rtl/adc_ctrl_pkg.sv
// Functional notes
// - External enable 0: only a software start/busy write begins conversion.
// - External enable 1: software write or external pin rising edge starts.
// - Done flag sets when the finished result becomes readable.
// - Done flag set with converter interrupt enabled raises the interrupt.
// - Software may clear the done flag; writing one does nothing.
// - Setting start/busy, by software or pin, launches a permitted conversion.
// - Start/busy reads one for the whole conversion.
// - At completion done flag sets first, start/busy clears right after.
// - Software writing zero to start/busy is ignored; no abort possible.
// - Starts while busy or done flag set are ignored, nothing disturbed; here a rejected start sets the reject status bit.
// - Three-bit channel field steers one of eight inputs to the converter.
// - Upper eight result bits in own register; two low bits on top.
// - Done set and busy cleared 50 machine cycles after command set.
// - Pin low one machine cycle, then high one; edge seen at cycle end.
package adc_ctrl_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 3;
    localparam int RES_W = 10;
    localparam int BYTE_W = 8;
    localparam int INT_W = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] RESULT_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 12'h008;
    localparam logic [ADDR_W-1:0] INT_MASK_OFS = 12'h00c;

    // control/status byte layout
    localparam int RES_LO_HI = 7;
    localparam int RES_LO_LO = 6;
    localparam int EXT_EN_BIT = 5;
    localparam int DONE_BIT = 4;
    localparam int BUSY_BIT = 3;
    localparam int CHAN_HI = 2;
    localparam int CHAN_LO = 0;
    localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;

    // interrupt status/mask layout
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REJECT_BIT = 1;
    localparam logic [INT_W-1:0] INT_RESET = 2'h0;

    // timing, in clocks and machine cycles
    localparam int MC_CLKS = 12;
    localparam int CONV_MC = 50;
    localparam int PRE_W = 4;
    localparam int MC_W = 6;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MC_CLKS - 1);
    localparam logic [MC_W-1:0] CONV_LAST = MC_W'(CONV_MC);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_FINISH
    } conv_state_t;
endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic pinIn,
    output logic pinOut
);
    logic stage1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // the pin idles high, so reset matches its idle level
            stage1 <= 1'b1;
            pinOut <= 1'b1;
        end else if (ce) begin
            stage1 <= pinIn;
            pinOut <= stage1;
        end
    end
endmodule // pin_sync

//--- sim/adc_core_model.sv
`timescale 1ns/1ns
module adc_core_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic convStart,
    input wire logic [2:0] chanSel,
    output logic [9:0] coreResult
);
    // result is coded by the channel sampled at launch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) coreResult <= 10'h000;
        else if (convStart) coreResult <= {chanSel, 7'h2b};
    end
endmodule // adc_core_model

//--- sim/adc_ctrl_props.sv
`timescale 1ns/1ns
module adc_ctrl_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic convStart,
    input wire logic [2:0] chanSel,
    input wire logic irq
);
    import adc_ctrl_pkg::*;
    logic [9:0] cnt;
    logic dn, ext;
    logic [1:0] m;
    wire wr = psel && penable && pready && pwrite;
    wire cw = wr && paddr == CTRL_OFS;
    wire rd = psel && pready && !pwrite && paddr == CTRL_OFS;
    wire go = cw && pwdata[BUSY_BIT] && cnt == 10'h000 && !dn;
    wire [2:0] wch = pwdata[CHAN_HI:CHAN_LO];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles since the launch pulse, stops after the interrupt slot
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cnt <= 10'h000;
        else if (convStart) cnt <= 10'h001;
        else if (cnt == 10'h259) cnt <= 10'h000;
        else if (cnt != 10'h000) cnt <= cnt + 10'h001;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) dn <= 1'b0;
        else if (cnt == 10'h257) dn <= 1'b1;
        else if (cw && !pwdata[DONE_BIT]) dn <= 1'b0;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) ext <= 1'b0;
        else if (cw) ext <= pwdata[EXT_EN_BIT];
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) m <= 2'h0;
        else if (wr && paddr == INT_MASK_OFS) m <= pwdata[1:0];
    end
    a_sw_start: assert property (go |=> convStart)
        else $error("software start gave no launch");
    a_start_gate: assert property (convStart |-> cnt == 10'h000 && !dn)
        else $error("launch while busy or result held");
    a_ext_gate: assert property (convStart |-> $past(go) || ext)
        else $error("pin launch with external start off");
    a_one_pulse: assert property (convStart |=> !convStart)
        else $error("launch pulse too long");
    a_busy_read: assert property (
        rd && cnt > 10'h001 && cnt < 10'h258 |-> prdata[BUSY_BIT])
        else $error("busy bit low during conversion");
    a_done_read: assert property (
        rd |-> prdata[DONE_BIT] == $past(dn))
        else $error("done flag read wrong");
    a_irq_on: assert property (cnt == 10'h259 && m[0] |-> irq)
        else $error("no interrupt after completion");
    a_irq_off: assert property (m == 2'h0 && $past(m) == 2'h0 |-> !irq)
        else $error("interrupt while masked");
    a_chan_out: assert property (
        cw |-> ##2 chanSel == $past(wch, 2))
        else $error("channel select not steered");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
endmodule // adc_ctrl_props
bind adc_start_status_control adc_ctrl_props props (.*);

//--- sim/test_adc_start_status_control.sv
`timescale 1ns/1ns
module test_adc_start_status_control;
    import adc_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic extPin = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, go, irq, e;
    logic [9:0] res;
    logic [2:0] ch;
    int miscompares = 0;
    int totalChecks = 0;
    int cyc = 0;
    int starts = 0;
    int t0;
    // flags (2 write, 1 error), address, write byte, read byte
    logic [35:0] rows [15] = '{36'h0_000_0_00_00, 36'h0_004_0_00_00,
        36'h0_008_0_00_00, 36'h0_00c_0_00_00, 36'h2_000_0_e7_00,
        36'h0_000_0_00_27, 36'h2_000_0_15_00, 36'h0_000_0_00_05,
        36'h2_00c_0_ff_00, 36'h0_00c_0_00_03, 36'h2_004_0_ff_00,
        36'h0_004_0_00_00, 36'h1_010_0_00_00, 36'h3_100_0_55_00,
        36'h0_000_0_00_05};
    adc_start_status_control DUT (.clk(clk), .rstn(rstn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_start_pin(extPin), .coreResult(res),
        .convStart(go), .chanSel(ch), .irq(irq));
    adc_core_model core (.clk(clk), .rstn(rstn), .convStart(go),
        .chanSel(ch), .coreResult(res));
    initial forever #4 clk = ~clk;
    // run needs about 1500 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (go === 1'b1) starts <= starts + 1;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic put(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic get(input logic [11:0] a, input logic [31:0] x,
            input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, x);
    endtask
    task automatic pulse();
        @(posedge clk);
        extPin <= 1'b0;
        repeat (30) @(posedge clk);
        extPin <= 1'b1;
        repeat (30) @(posedge clk);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i][33], rows[i][31:20], {24'h0, rows[i][15:8]});
            if (!rows[i][33]) chk("rdata", q, {24'h0, rows[i][7:0]});
            chk("slverr", {31'h0, e}, {31'h0, rows[i][32]});
        end
        put(INT_MASK_OFS, 32'h1);
        put(CTRL_OFS, 32'h3);
        put(CTRL_OFS, 32'hb);
        t0 = cyc;
        get(CTRL_OFS, 32'hb, "busy");
        chk("chan", {29'h0, ch}, 32'h3);
        put(CTRL_OFS, 32'h3);
        put(CTRL_OFS, 32'hb);
        get(CTRL_OFS, 32'hb, "noabort");
        get(INT_STATUS_OFS, 32'h2, "reject");
        put(INT_STATUS_OFS, 32'h2);
        while (irq !== 1'b1 && cyc - t0 < 700) @(negedge clk);
        chk("irqat", cyc - t0, 32'h25a);
        get(CTRL_OFS, 32'hd3, "done");
        get(RESULT_OFS, 32'h6a, "result");
        get(INT_STATUS_OFS, 32'h1, "status");
        put(CTRL_OFS, 32'h3);
        put(INT_STATUS_OFS, 32'h1);
        get(CTRL_OFS, 32'hc3, "cleared");
        chk("irqoff", {31'h0, irq}, 32'h0);
        pulse();
        chk("pinoff", starts, 32'h1);
        put(CTRL_OFS, 32'h25);
        put(INT_MASK_OFS, 32'h0);
        pulse();
        chk("pinon", starts, 32'h2);
        get(CTRL_OFS, 32'hed, "pinbusy");
        pulse();
        chk("busypin", starts, 32'h2);
        do begin
            apb(1'b0, CTRL_OFS, 32'h0);
        end while (q[DONE_BIT] !== 1'b1);
        chk("masked", {31'h0, irq}, 32'h0);
        pulse();
        chk("heldpin", starts, 32'h2);
        get(RESULT_OFS, 32'haa, "result5");
        put(INT_MASK_OFS, 32'h1);
        get(INT_MASK_OFS, 32'h1, "mask");
        chk("irqon", {31'h0, irq}, 32'h1);
        put(CTRL_OFS, 32'h0);
        put(CTRL_OFS, 32'h8);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        get(CTRL_OFS, 32'h0, "reset");
        chk("irqrst", {31'h0, irq}, 32'h0);
        conclude();
    end
endmodule // test_adc_start_status_control
